/* shared/ssd_defs.svh */
// Register offsets, field positions and reset values of the safety status bank
`ifndef SSD_DEFS_SVH
`define SSD_DEFS_SVH
`define SSD_OFF_STATUS_ONE 12'h000
`define SSD_OFF_STATUS_TWO 12'h004
`define SSD_OFF_TIME_LEFT 12'h008
`define SSD_OFF_PASSWORD 12'h00c
`define SSD_OFF_OPER_DIAG 12'h010
`define SSD_OFF_FAULT_ITEM 12'h014
`define SSD_OFF_BRAKE_EN 12'h018
`define SSD_OFF_RX_BASE 12'h040
`define SSD_OFF_TX_BASE 12'h060
`define SSD_OFF_VER_BASE 12'h080
`define SSD_OFF_CSUM_BASE 12'h090
`define SSD_OFF_STAMP_BASE 12'h098
`define SSD_BIT_STO 0
`define SSD_BIT_SS1 1
`define SSD_BIT_SS2 2
`define SSD_BIT_SOS 3
`define SSD_BIT_SLS 4
`define SSD_BIT_SOS_SEL 5
`define SSD_BIT_SLS_SEL 6
`define SSD_BIT_EVENT 7
`define SSD_BIT_STAGE_LO 9
`define SSD_BIT_DIRP_1 12
`define SSD_BIT_DIRN_1 13
`define SSD_BIT_MSG 15
`define SSD_BIT_DIRP_2 8
`define SSD_BIT_DIRN_2 9
`define SSD_BIT_TSTOP_ACT 12
`define SSD_BIT_TSTOP_REQ 13
`define SSD_BIT_PW_SET 0
`define SSD_BIT_PW_WRITE 1
`define SSD_BIT_BRAKE_EN 0
`define SSD_BRAKE_RESET 32'h0000_0000
`endif

/* shared/ssd_pkg.sv */
// Types shared by the safety status bank
package ssd_pkg;
    // AHB transfer types used by the slave
    typedef enum logic [1:0] {
        SSD_IDLE = 2'h0,
        SSD_BUSY = 2'h1,
        SSD_NONSEQ = 2'h2,
        SSD_SEQ = 2'h3
    } ssd_htrans_t;
    // One 16-bit process data word
    typedef logic [15:0] ssd_word_t;
endpackage

/* core/ssd_bank.sv */
// Safety status and diagnostic register bank with an AHB-Lite slave
//
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "ssd_defs.svh"

// Summary of operation
// RULE1 - Status one bits 0-4 show active stops
// RULE2 - Status one bits 5,6,9,10,12,13 show selections
// RULE3 - Status one bit 7 shows internal stop
// RULE4 - Status one bit 15 shows pending message
// RULE5 - Status two direction and test stop bits
// RULE6 - Report time left until forced check
// RULE7 - Password bit 0 set, also output pin
// RULE8 - Password bit 1 only when bit 0
// RULE9 - Mirror eight received telegram words
// RULE10 - Mirror eight sent telegram words
// RULE11 - Version readable as four 16-bit fields
// RULE12 - Diag bit 0 power cycle needed
// RULE13 - Diag bit 1 safety functions active
// RULE14 - Diag bit 2 replaced, save needed
// RULE15 - Diag bit 3 replaced, acknowledge and save
// RULE16 - Two 32-bit change checksums kept
// RULE17 - Time stamp stored on checksum change
// RULE18 - Record cross-check item causing stop F
// RULE19 - Brake test enable resets to zero
// RULE20 - Brake enable bit 0 enables test
// RULE21 - Status updated together each monitoring cycle
module ssd_bank (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic mon_tick,
    input wire logic [4:0] stop_active,
    input wire logic sos_selected,
    input wire logic sls_selected,
    input wire logic [1:0] sls_stage,
    input wire logic dir_pos_selected,
    input wire logic dir_neg_selected,
    input wire logic [5:0] stop_class_active,
    input wire logic message_pending,
    input wire logic test_stop_active,
    input wire logic test_stop_required,
    input wire logic [31:0] check_time_left,
    input wire logic password_assigned,
    input wire logic password_entered,
    input wire logic rx_valid,
    input wire logic [127:0] rx_words,
    input wire logic tx_valid,
    input wire logic [127:0] tx_words,
    input wire logic [63:0] version_in,
    input wire logic param_change_pending,
    input wire logic functions_enabled,
    input wire logic replaced_save_needed,
    input wire logic replaced_ack_needed,
    input wire logic [1:0] csum_load,
    input wire logic [31:0] csum_value,
    input wire logic [31:0] time_now,
    input wire logic fault_load,
    input wire logic [31:0] fault_item,
    output logic password_set_out,
    output logic brake_test_on
);
    // Snapshot registers loaded on the monitoring tick, plus the brake enable and fault item words
    logic [15:0] status_one;
    logic [15:0] status_two;
    logic [31:0] time_left;
    logic [1:0] password;
    logic [3:0] oper_diag;
    logic [31:0] brake_en;
    logic [31:0] fault_reg;
    // Telegram mirrors and version fields as word arrays, checksums and stamps as 32-bit arrays
    ssd_pkg::ssd_word_t rx_mem [0:7];
    ssd_pkg::ssd_word_t tx_mem [0:7];
    ssd_pkg::ssd_word_t ver_mem [0:3];
    logic [31:0] csum_mem [0:1];
    logic [31:0] stamp_mem [0:1];
    // Data phase bookkeeping; only writes need the held address
    logic dp_write;
    logic [11:0] dp_addr;

    // Combined status words, built from the live inputs
    wire logic [15:0] next_status_one;
    wire logic [15:0] next_status_two;
    wire logic next_event;
    // RULE3 any stop class
    assign next_event = |stop_class_active;
    // RULE1 active stops, RULE2 selections, RULE4 message
    assign next_status_one = {message_pending, 1'b0, dir_neg_selected,
        dir_pos_selected, 1'b0, sls_stage, 1'b0, next_event,
        sls_selected, sos_selected, stop_active};
    // RULE5 direction and test stop bits
    assign next_status_two = {2'h0, test_stop_required, test_stop_active,
        2'h0, dir_neg_selected, dir_pos_selected, 8'h00};

    // Address phase qualification; only whole-word writes reach a register
    wire logic addr_ok;
    wire logic take_read;
    wire logic take_write;
    assign addr_ok = hsel && hready && htrans[1];
    assign take_read = addr_ok && !hwrite;
    assign take_write = addr_ok && hwrite && (hsize == 3'h2);

    // Reads are decoded from the live address phase so that hrdata is
    // ready by the data phase edge; a decode on the held address would
    // hand the master the word of the previous read
    wire logic [11:0] rd_addr_live;
    assign rd_addr_live = {haddr[11:2], 2'h0};

    // Region base addresses as full-width nets, sliced for the compares
    wire logic [11:0] rx_base;
    wire logic [11:0] tx_base;
    wire logic [11:0] ver_base;
    wire logic [11:0] csum_base;
    wire logic [11:0] stamp_base;
    assign rx_base = `SSD_OFF_RX_BASE;
    assign tx_base = `SSD_OFF_TX_BASE;
    assign ver_base = `SSD_OFF_VER_BASE;
    assign csum_base = `SSD_OFF_CSUM_BASE;
    assign stamp_base = `SSD_OFF_STAMP_BASE;

    // Array index and region decodes on the address phase address
    wire logic [2:0] idx8;
    wire logic idx1;
    wire logic in_rx;
    wire logic in_tx;
    wire logic in_ver;
    wire logic in_csum;
    wire logic in_stamp;
    assign idx8 = rd_addr_live[4:2];
    assign idx1 = rd_addr_live[2];
    assign in_rx = (rd_addr_live[11:5] == rx_base[11:5]);
    assign in_tx = (rd_addr_live[11:5] == tx_base[11:5]);
    assign in_ver = (rd_addr_live[11:4] == ver_base[11:4]);
    assign in_csum = (rd_addr_live[11:3] == csum_base[11:3]);
    assign in_stamp = (rd_addr_live[11:3] == stamp_base[11:3]);

    // Read multiplexer; unmapped addresses read zero with an OKAY answer
    logic [31:0] read_mux;
    always_comb begin
        read_mux = 32'h0000_0000;
        if (in_rx) begin
            read_mux = {16'h0000, rx_mem[idx8]};
        end else if (in_tx) begin
            read_mux = {16'h0000, tx_mem[idx8]};
        end else if (in_ver) begin
            read_mux = {16'h0000, ver_mem[idx8[1:0]]};
        end else if (in_csum) begin
            read_mux = csum_mem[idx1];
        end else if (in_stamp) begin
            read_mux = stamp_mem[idx1];
        end else begin
            case (rd_addr_live)
                `SSD_OFF_STATUS_ONE: read_mux = {16'h0000, status_one};
                `SSD_OFF_STATUS_TWO: read_mux = {16'h0000, status_two};
                `SSD_OFF_TIME_LEFT: read_mux = time_left;
                `SSD_OFF_PASSWORD: read_mux = {30'h0, password};
                `SSD_OFF_OPER_DIAG: read_mux = {28'h0, oper_diag};
                `SSD_OFF_FAULT_ITEM: read_mux = fault_reg;
                `SSD_OFF_BRAKE_EN: read_mux = brake_en;
                default: read_mux = 32'h0000_0000;
            endcase
        end
    end

    // Bus slave: zero wait states, answer always OKAY
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dp_write <= 1'b0;
            dp_addr <= 12'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            dp_write <= take_write;
            if (addr_ok) begin
                dp_addr <= {haddr[11:2], 2'h0};
            end
        end
    end

    // Read data is registered at the address phase edge and stands
    // through the data phase until the next read is taken
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (take_read) begin
            hrdata <= read_mux;
        end
    end

    // Brake test enable word, the only writable register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // RULE19 disabled by default
            brake_en <= `SSD_BRAKE_RESET;
            brake_test_on <= 1'b0;
        end else begin
            if (dp_write && dp_addr == `SSD_OFF_BRAKE_EN) begin
                brake_en <= hwdata;
            end
            // RULE20 bit 0 drives the test enable
            brake_test_on <= brake_en[`SSD_BIT_BRAKE_EN];
        end
    end

    // Snapshot of status and diagnostic words on each monitoring tick
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status_one <= 16'h0000;
            status_two <= 16'h0000;
            time_left <= 32'h0000_0000;
            password <= 2'h0;
            oper_diag <= 4'h0;
            password_set_out <= 1'b0;
        // RULE21 one coherent update per cycle
        end else if (mon_tick) begin
            status_one <= next_status_one;
            status_two <= next_status_two;
            // RULE6 time left until forced check
            time_left <= check_time_left;
            // RULE7 assigned, RULE8 entered only when assigned
            password <= {password_entered && password_assigned,
                password_assigned};
            password_set_out <= password_assigned;
            // RULE12 RULE13 RULE14 RULE15 operating diagnostics
            oper_diag <= {replaced_ack_needed, replaced_save_needed,
                functions_enabled, param_change_pending};
        end
    end

    // Telegram mirrors and version fields
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 8; i++) begin
            if (rst) begin
                rx_mem[i] <= 16'h0000;
                tx_mem[i] <= 16'h0000;
            end else begin
                // RULE9 received telegram including trailer
                if (rx_valid) begin
                    rx_mem[i] <= rx_words[i*16 +: 16];
                end
                // RULE10 telegram about to be sent
                if (tx_valid) begin
                    tx_mem[i] <= tx_words[i*16 +: 16];
                end
            end
        end
        // RULE11 version fields, major first
        for (int j = 0; j < 4; j++) begin
            if (rst) begin
                ver_mem[j] <= 16'h0000;
            end else begin
                ver_mem[j] <= version_in[j*16 +: 16];
            end
        end
    end

    // Checksums and their time stamps, plus the stop F item
    always_ff @(posedge sys_clk) begin
        for (int k = 0; k < 2; k++) begin
            if (rst) begin
                csum_mem[k] <= 32'h0000_0000;
                stamp_mem[k] <= 32'h0000_0000;
            // RULE16 checksum update, RULE17 stamp with it
            end else if (csum_load[k]) begin
                csum_mem[k] <= csum_value;
                stamp_mem[k] <= time_now;
            end
        end
        if (rst) begin
            fault_reg <= 32'h0000_0000;
        // RULE18 cross-check item that caused stop F
        end else if (fault_load) begin
            fault_reg <= fault_item;
        end
    end

    // RULE3 event bit follows stop classes
    a_event_bit: assert property ( // RULE3
        @(posedge sys_clk) disable iff (rst)
        mon_tick |=> status_one[`SSD_BIT_EVENT] == $past(|stop_class_active))
        else $error("internal event bit wrong");
    // RULE1 active stop bits
    a_stop_bits: assert property ( // RULE1
        @(posedge sys_clk) disable iff (rst)
        mon_tick |=> status_one[4:0] == $past(stop_active))
        else $error("stop active bits wrong");
    // RULE2 selection bits
    a_select_bits: assert property ( // RULE2
        @(posedge sys_clk) disable iff (rst)
        mon_tick |=> {status_one[13:12], status_one[10:9],
            status_one[6:5]} == $past({dir_neg_selected, dir_pos_selected,
            sls_stage, sls_selected, sos_selected}))
        else $error("selection bits wrong");
    // RULE4 message bit
    a_msg_bit: assert property ( // RULE4
        @(posedge sys_clk) disable iff (rst)
        mon_tick |=> status_one[`SSD_BIT_MSG] == $past(message_pending))
        else $error("message bit wrong");
    // RULE8 entered implies assigned
    a_password_order: assert property ( // RULE8
        @(posedge sys_clk) disable iff (rst)
        password[`SSD_BIT_PW_WRITE] |-> password[`SSD_BIT_PW_SET])
        else $error("password entered without assignment");
    // RULE7 password output pin
    a_password_pin: assert property ( // RULE7
        @(posedge sys_clk) disable iff (rst)
        mon_tick |=> password_set_out == $past(password_assigned))
        else $error("password output wrong");
    // RULE21 status holds between ticks
    a_status_hold: assert property ( // RULE21
        @(posedge sys_clk) disable iff (rst)
        !mon_tick |=> $stable(status_one) && $stable(status_two))
        else $error("status changed off tick");
    // RULE5 test stop bits
    a_test_stop: assert property ( // RULE5
        @(posedge sys_clk) disable iff (rst)
        mon_tick |=> status_two[13:12] ==
            $past({test_stop_required, test_stop_active}))
        else $error("test stop bits wrong");
    // RULE5 direction bits of word two
    a_dir_two: assert property ( // RULE5
        @(posedge sys_clk) disable iff (rst)
        mon_tick |=> status_two[9:8] ==
            $past({dir_neg_selected, dir_pos_selected}))
        else $error("direction bits of word two wrong");
    // RULE6 time left snapshot
    a_time_left: assert property ( // RULE6
        @(posedge sys_clk) disable iff (rst)
        mon_tick |=> time_left == $past(check_time_left))
        else $error("time left not captured");
    // RULE12 RULE13 RULE14 RULE15 diagnostic bits
    a_oper_diag: assert property ( // RULE12 RULE13 RULE14 RULE15
        @(posedge sys_clk) disable iff (rst)
        mon_tick |=> oper_diag == $past({replaced_ack_needed,
            replaced_save_needed, functions_enabled, param_change_pending}))
        else $error("diagnostic bits wrong");
    // RULE9 trailer word mirrored
    a_rx_mirror: assert property ( // RULE9
        @(posedge sys_clk) disable iff (rst)
        rx_valid |=> rx_mem[7] == $past(rx_words[127:112]))
        else $error("received trailer not mirrored");
    // RULE10 first sent word mirrored
    a_tx_mirror: assert property ( // RULE10
        @(posedge sys_clk) disable iff (rst)
        tx_valid |=> tx_mem[0] == $past(tx_words[15:0]))
        else $error("sent word not mirrored");
    // RULE11 hotfix field follows input; the sampled reset keeps the
    // edge on which the design still sees reset out of the check
    a_version: assert property ( // RULE11
        @(posedge sys_clk) disable iff (rst)
        !rst |=> ver_mem[3] == $past(version_in[63:48]))
        else $error("version field wrong");
    // RULE16 second checksum load
    a_csum_load: assert property ( // RULE16
        @(posedge sys_clk) disable iff (rst)
        csum_load[1] |=> csum_mem[1] == $past(csum_value))
        else $error("checksum not stored");
    // RULE17 stamp follows checksum load
    a_stamp_load: assert property ( // RULE17
        @(posedge sys_clk) disable iff (rst)
        csum_load[0] |=> stamp_mem[0] == $past(time_now))
        else $error("time stamp not stored");
    // RULE19 enable word cleared by reset
    a_brake_reset: assert property ( // RULE19
        @(posedge sys_clk)
        rst |=> brake_en == `SSD_BRAKE_RESET && !brake_test_on)
        else $error("brake enable not cleared");
    // RULE20 enable output follows bit 0 two cycles after write
    a_brake_en: assert property ( // RULE20
        @(posedge sys_clk) disable iff (rst)
        (dp_write && dp_addr == `SSD_OFF_BRAKE_EN) |=> ##1
            brake_test_on == $past(hwdata[0], 2))
        else $error("brake enable wrong");
    // RULE18 fault item captured
    a_fault_item: assert property ( // RULE18
        @(posedge sys_clk) disable iff (rst)
        fault_load |=> fault_reg == $past(fault_item))
        else $error("fault item not captured");
endmodule

/* verif/ssd_ctrl_model.sv */
// Safety controller model that sends control telegrams to the bank
`timescale 1ns/1ps
module ssd_ctrl_model (
    input wire logic sys_clk,
    input wire logic send,
    input wire logic [95:0] payload,
    output logic rx_valid,
    output logic [127:0] rx_words
);
    // Telegram count, carried in the last trailer word
    logic [15:0] seq = 16'h0000;
    initial rx_valid = 1'b0;
    initial rx_words = '0;
    // One-cycle valid with a two-word trailer; between telegrams the
    // words churn every cycle so a late sample cannot pass as good
    always @(posedge sys_clk) begin
        if (send) begin
            rx_valid <= 1'b1;
            rx_words <= {seq, payload[15:0] ^ payload[95:80], payload};
            seq <= seq + 16'h0001;
        end else begin
            rx_valid <= 1'b0;
            rx_words <= ~rx_words;
        end
    end
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the safety status bank
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 0, rst = 1, hsel = 0, hwrite = 0, mon_tick = 0;
    logic [11:0] haddr = 0;
    logic [1:0] htrans = 0, csum_load = 0;
    logic [2:0] hsize = 0;
    logic [31:0] hwdata = 0, hrdata, st = 0, tl = 0, csv = 0, tn = 0, fi = 0;
    logic hreadyout, hresp, pw_out, brake_on, rx_valid, send = 0;
    logic tx_valid = 0, fl = 0;
    logic [127:0] rx_words, tx_words = 0, rx_cap, tx_exp;
    logic [95:0] pay = 0;
    logic [63:0] ver = 0;
    logic [31:0] seed = 32'h394d141f, snap, r, cs[2], ts[2];
    int err_count = 0, checked = 0;
    // Half period of a 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;
    // Keep what the controller really sent
    always @(posedge sys_clk) if (rx_valid) rx_cap <= rx_words;
    ssd_ctrl_model i_ssd_ctrl_model (.sys_clk(sys_clk), .send(send),
        .payload(pay), .rx_valid(rx_valid), .rx_words(rx_words));
    // Field map of st: stops, selections, classes, flags, diag
    ssd_bank i_ssd_bank (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .mon_tick(mon_tick),
        .stop_active(st[4:0]), .sos_selected(st[5]),
        .sls_selected(st[6]), .sls_stage(st[8:7]),
        .dir_pos_selected(st[9]), .dir_neg_selected(st[10]),
        .stop_class_active(st[16:11]), .message_pending(st[17]),
        .test_stop_active(st[18]), .test_stop_required(st[19]),
        .check_time_left(tl), .password_assigned(st[20]),
        .password_entered(st[21]), .rx_valid(rx_valid),
        .rx_words(rx_words), .tx_valid(tx_valid), .tx_words(tx_words),
        .version_in(ver), .param_change_pending(st[22]),
        .functions_enabled(st[23]), .replaced_save_needed(st[24]),
        .replaced_ack_needed(st[25]), .csum_load(csum_load),
        .csum_value(csv), .time_now(tn), .fault_load(fl),
        .fault_item(fi), .password_set_out(pw_out),
        .brake_test_on(brake_on));
    // Galois shift register for the random stimulus
    function automatic logic [31:0] lf(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    // Expected images of status one and status two
    function automatic logic [31:0] s1(input logic [31:0] s);
        return {16'h0, s[17], 1'b0, s[10], s[9], 1'b0, s[8:7], 1'b0,
            |s[16:11], s[6], s[5], s[4:0]};
    endfunction
    function automatic logic [31:0] s2(input logic [31:0] s);
        return {18'h0, s[19], s[18], 2'h0, s[10], s[9], 8'h0};
    endfunction
    // Mismatch report and bookkeeping
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Bounded wait for hready at a rising edge
    task automatic wt;
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (n >= 100) begin
            err_count++;
            summarize();
        end
    endtask
    // One single AHB transfer; read data is taken at the data phase edge
    task automatic ahb(input logic w, input logic [2:0] sz,
        input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= sz;
        wt();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wt();
        r = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        ahb(1'b0, 3'h2, a, 32'h0);
        chk(r, e);
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rc(12'h018, 32'h0);
        // Snapshot taken at the tick must survive later input changes
        for (int i = 0; i < 6; i++) begin
            seed = lf(seed);
            snap = (i == 0) ? seed & 32'hfffe07ff : seed;
            st <= snap;
            tl <= ~seed;
            @(posedge sys_clk) mon_tick <= 1'b1;
            @(posedge sys_clk) mon_tick <= 1'b0;
            st <= lf(seed);
            tl <= seed;
            rc(12'h000, s1(snap));
            rc(12'h004, s2(snap));
            rc(12'h008, ~seed);
            rc(12'h00c, {30'h0, snap[21] & snap[20], snap[20]});
            chk({31'h0, pw_out}, {31'h0, snap[20]});
            rc(12'h010, {28'h0, snap[25:22]});
        end
        // Telegrams in both directions, then the released words churn
        pay <= {seed, ~seed, seed};
        send <= 1'b1;
        tx_exp = {~seed, seed, lf(seed), seed};
        tx_words <= tx_exp;
        tx_valid <= 1'b1;
        @(posedge sys_clk) send <= 1'b0;
        tx_valid <= 1'b0;
        tx_words <= ~tx_exp;
        repeat (2) @(posedge sys_clk);
        ver <= {seed, lf(seed)};
        for (int i = 0; i < 8; i++) begin
            rc(12'h040 + 12'(i * 4), {16'h0, rx_cap[16 * i +: 16]});
            rc(12'h060 + 12'(i * 4), {16'h0, tx_exp[16 * i +: 16]});
        end
        for (int i = 0; i < 4; i++)
            rc(12'h080 + 12'(i * 4), {16'h0, ver[16 * i +: 16]});
        // The second checksum load leaves the first index alone
        for (int k = 0; k < 2; k++) begin
            seed = lf(seed);
            cs[k] = seed;
            ts[k] = ~seed;
            csv <= cs[k];
            tn <= ts[k];
            csum_load <= 2'(1 << k);
            fi <= seed;
            fl <= 1'b1;
            @(posedge sys_clk) csum_load <= 2'h0;
            fl <= 1'b0;
            for (int j = 0; j <= k; j++) begin
                rc(12'h090 + 12'(j * 4), cs[j]);
                rc(12'h098 + 12'(j * 4), ts[j]);
            end
            rc(12'h014, seed);
        end
        // Brake enable, refused writes and an unmapped place
        ahb(1'b1, 3'h2, 12'h018, 32'h1);
        rc(12'h018, 32'h1);
        chk({31'h0, brake_on}, 32'h1);
        ahb(1'b1, 3'h1, 12'h018, 32'h0);
        rc(12'h018, 32'h1);
        ahb(1'b1, 3'h2, 12'h000, 32'hffff);
        rc(12'h000, s1(snap));
        rc(12'h0fc, 32'h0);
        // Second reset in mid-run clears the enable again
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rc(12'h018, 32'h0);
        chk({31'h0, brake_on}, 32'h0);
        summarize();
    end
endmodule
